//--- inc/line_setup_params.svh
// Purpose: constants of the channel line setup block
// Assumes: one channel per instance, byte wide host port
// Notes:   types live in line_setup_pkg
`ifndef LINE_SETUP_PARAMS_SVH
`define LINE_SETUP_PARAMS_SVH
`define LS_OFF_A 8'h22
`define LS_OFF_B 8'h2a
`define FA_OFF_A 8'h23
`define FA_OFF_B 8'h2b
`define PTR_OFF_A 8'h00
`define PTR_OFF_B 8'h08
`define PTR_LS 2'h2
`define PTR_FA 2'h3
`define PTR_LAST 2'h3
`define MODE_HI 7
`define MODE_LO 6
`define RTS_AUTO_BIT 5
`define CTS_EN_BIT 4
`define STOP_HI 3
`define STOP_LO 0
`define EXT_STOP_BIT 1
`define STRIP_FLOW_BIT 7
`define STRIP_ADDR_BIT 6
`define FLOW_HI 3
`define FLOW_LO 2
`define FA_RW_MASK 8'hcf
`define LS_RESET 8'h00
`define FA_RESET 8'h00
`define SUB_PER_BIT 6'h10
`define SUB_MID 4'h8
`define STOP_BASE_LO 6'h09
`define STOP_BASE_HI 6'h11
`define STOP_FIVE_ADD 6'h08
`define XOFF_LEVEL 9'h0f0
`define XON_LEVEL 9'h080
`endif

//--- inc/line_setup_pkg.sv
// Purpose: shared types of the channel line setup block
// Assumes: encodings follow the mode field order
// Notes:   constants sit in line_setup_params.svh
package line_setup_pkg;
  // Channel mode field, order gives 0..3
  typedef enum logic [1:0] {
    MODE_NORMAL, MODE_ECHO, MODE_LOCAL, MODE_REMOTE
  } chan_mode_t;
  // Transmit engine states
  typedef enum logic [2:0] {
    TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP
  } tx_state_t;
endpackage

//--- verilog/line_setup.sv
// Purpose: channel mode, flow control and stop length logic
// Assumes: ticks are one-cycle pulses at 16x (or 1x) rate
// Notes:   receiver core sits outside, fed by RX_LINE_O
`timescale 1ns/1ns
`include "line_setup_params.svh"

// Transmit queue, registered full flag
module tx_queue #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // Filling side
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  // Draining side
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  // Pointer wrap needs a power of two
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
    $error("tx_queue depth must be a power of two");
  end
  logic [WIDTH-1:0] mem_q [DEPTH];   // Storage
  logic [AW-1:0]    wr_q;            // Write pointer
  logic [AW-1:0]    rd_q;            // Read pointer
  logic [AW:0]      cnt_q;           // Fill count
  logic             full_q;          // Registered full
  logic             push;            // Word taken
  logic             pop;             // Word given
  logic [AW:0]      cnt_d;           // Next count

  assign push        = in_valid_i && !full_q;
  assign pop         = out_valid_o && out_ready_i;
  assign cnt_d       = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign in_ready_o  = !full_q;
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rd_q];

  // Storage write, no reset needed on data
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  // Pointers and count
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_q   <= '0;
      rd_q   <= '0;
      cnt_q  <= '0;
      full_q <= 1'b0;
    end else begin
      wr_q   <= wr_q + AW'(push);
      rd_q   <= rd_q + AW'(pop);
      cnt_q  <= cnt_d;
      full_q <= (cnt_d == (AW+1)'(DEPTH));
    end
  end
endmodule // tx_queue

// One channel of mode, loop, flow and stop control
module line_setup #(
  parameter logic       IS_CHAN_B = 1'b0,  // Selects B offsets
  parameter int         TXQ_DEPTH = 4,     // Transmit queue words
  parameter logic [7:0] XON_CODE  = 8'h11, // Resume character
  parameter logic [7:0] XOFF_CODE = 8'h13  // Pause character
) (
  // Clock and reset
  input  wire logic       CLK_I,
  input  wire logic       RSTN_I,
  // Host register port
  input  wire logic [7:0] ADDR_I,
  input  wire logic [7:0] WDATA_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  output logic      [7:0] RDATA_O,
  // Host commands and format
  input  wire logic       TX_EN_I,
  input  wire logic       RTS_SET_I,
  input  wire logic       RTS_CLR_I,
  input  wire logic       SEND_XON_I,
  input  wire logic       SEND_XOFF_I,
  input  wire logic       ERR_RESET_I,
  input  wire logic       BLOCK_ERR_I,
  input  wire logic [1:0] BITS_I,
  input  wire logic       PAR_EN_I,
  input  wire logic       PAR_ODD_I,
  // Host transmit data
  input  wire logic [7:0] TXD_DATA_I,
  input  wire logic       TXD_VALID_I,
  output logic            TXD_READY_O,
  output logic            TX_RDY_O,
  output logic            TX_IDLE_O,
  // Baud ticks
  input  wire logic       TX_TICK_I,
  input  wire logic       RX_TICK_I,
  input  wire logic       TX_EXT1X_I,
  // Serial pins
  input  wire logic       RXD_I,
  output logic            TXD_O,
  input  wire logic       CTS_N_I,
  output logic            RTS_N_O,
  // Receiver core side
  output logic            RX_LINE_O,
  output logic            RX_TICK_O,
  input  wire logic [7:0] RXC_DATA_I,
  input  wire logic       RXC_VALID_I,
  input  wire logic [2:0] RXC_STAT_I,
  input  wire logic       RXC_FLOW_I,
  input  wire logic       RXC_XOFF_I,
  input  wire logic       RXC_ADDR_I,
  input  wire logic [8:0] RXQ_LEVEL_I,
  // Receive queue side
  output logic            RXQ_WR_O,
  output logic      [7:0] RXQ_DATA_O,
  output logic      [2:0] RXQ_STAT_O,
  output logic      [2:0] ERR_ACC_O,
  output logic            RECOG_O
);
  // Register state
  logic [7:0] mr2_q;        // Line setup register
  logic [7:0] mr3_q;        // Flow and address register
  logic [1:0] ptr_q;        // Legacy pointer
  // Transmit engine
  line_setup_pkg::tx_state_t st_q;
  logic [5:0] sub_q;        // Ticks within bit
  logic [2:0] bit_q;        // Data bit index
  logic [7:0] sh_q;         // Shift register
  logic       par_q;        // Running parity
  logic [1:0] send_q;       // Pending {xoff,xon}
  logic       hold_q;       // Paused by Xoff
  logic       xoff_sent_q;  // Auto rx paused partner
  logic       armed_q;      // Auto negation armed
  logic [5:0] rts_cnt_q;    // Bit time after empty
  logic [3:0] rx_ph_q;      // Receiver 1X phase
  logic       echo_q;       // Re-clocked received bit

  // Address decode
  logic [7:0] ls_off, fa_off, ptr_off;
  logic       ptr_hit, ls_hit, fa_hit;
  assign ls_off  = IS_CHAN_B ? `LS_OFF_B : `LS_OFF_A;
  assign fa_off  = IS_CHAN_B ? `FA_OFF_B : `FA_OFF_A;
  assign ptr_off = IS_CHAN_B ? `PTR_OFF_B : `PTR_OFF_A;
  assign ptr_hit = (ADDR_I == ptr_off);
  // Direct offsets and pointer stage both reach a register
  assign ls_hit  = (ADDR_I == ls_off)
                 || (ptr_hit && ptr_q == `PTR_LS);
  assign fa_hit  = (ADDR_I == fa_off)
                 || (ptr_hit && ptr_q == `PTR_FA);

  // Field decode
  line_setup_pkg::chan_mode_t mode;
  logic       is_echo, is_local, is_remote, resend;
  logic [1:0] flow_mode;
  assign mode      = line_setup_pkg::chan_mode_t'(
                       mr2_q[`MODE_HI:`MODE_LO]);
  assign is_echo   = (mode == line_setup_pkg::MODE_ECHO);
  assign is_local  = (mode == line_setup_pkg::MODE_LOCAL);
  assign is_remote = (mode == line_setup_pkg::MODE_REMOTE);
  assign resend    = is_echo || is_remote;
  assign flow_mode = mr3_q[`FLOW_HI:`FLOW_LO];

  // Stop length in ticks
  function automatic logic [5:0] stop_len(
    input logic       ext,
    input logic [3:0] code,
    input logic       five
  );
    logic [5:0] s;
    s = (code[3] ? `STOP_BASE_HI : `STOP_BASE_LO)
      + {2'h0, code};
    if (five && !code[3]) begin
      s = s + `STOP_FIVE_ADD;
    end
    if (ext) begin
      s = code[`EXT_STOP_BIT] ? 6'h02 : 6'h01;
    end
    return s;
  endfunction

  // Ticks per bit, 1 with an external 1X clock
  function automatic logic [5:0] bit_len(input logic ext);
    return ext ? 6'h01 : `SUB_PER_BIT;
  endfunction

  // Queue between host and engine
  logic [7:0] q_data;
  logic       q_valid, q_ready, q_push, q_pop;
  // No host path while resending; dropped words stay dropped
  assign q_push = TXD_VALID_I && TX_EN_I && !resend;
  tx_queue #(
    .WIDTH (8),
    .DEPTH (TXQ_DEPTH)
  ) u_txq (
    .clk_i       (CLK_I),
    .rst_n_i     (RSTN_I),
    .in_data_i   (TXD_DATA_I),
    .in_valid_i  (q_push),
    .in_ready_o  (q_ready),
    .out_data_o  (q_data),
    .out_valid_o (q_valid),
    .out_ready_i (q_pop)
  );

  // Engine decode
  logic [5:0] lim, blen;
  logic [2:0] last_bit;
  logic       bit_end, cts_ok, flow_go, data_go, start;
  logic       tx_bit, tx_done;
  logic [7:0] next_char;
  assign blen     = bit_len(TX_EXT1X_I);
  assign lim      = (st_q == line_setup_pkg::TX_STOP)
                  ? stop_len(TX_EXT1X_I, mr2_q[`STOP_HI:`STOP_LO],
                             BITS_I == 2'h0)
                  : blen;
  assign bit_end  = TX_TICK_I && (st_q != line_setup_pkg::TX_IDLE)
                  && (sub_q == lim - 6'h01);
  assign last_bit = {1'b0, BITS_I} + 3'h4;
  // Sampled only when idle, so mid-character edges are ignored
  assign cts_ok   = !mr2_q[`CTS_EN_BIT] || !CTS_N_I;
  assign flow_go  = (send_q != 2'h0);
  assign data_go  = q_valid && !hold_q && !resend;
  assign start    = (st_q == line_setup_pkg::TX_IDLE) && TX_TICK_I
                  && cts_ok && (flow_go || data_go);
  assign q_pop    = start && !flow_go;
  assign next_char = send_q[1] ? XOFF_CODE
                   : send_q[0] ? XON_CODE : q_data;
  assign tx_done  = (st_q == line_setup_pkg::TX_IDLE)
                  && !q_valid && !flow_go;

  // Line level of the engine, marking while idle
  always_comb begin
    unique case (st_q)
      line_setup_pkg::TX_IDLE:   tx_bit = 1'b1;
      line_setup_pkg::TX_START:  tx_bit = 1'b0;
      line_setup_pkg::TX_DATA:   tx_bit = sh_q[0];
      line_setup_pkg::TX_PARITY: tx_bit = par_q;
      line_setup_pkg::TX_STOP:   tx_bit = 1'b1;
      // Unused codes rest at mark
      default:                   tx_bit = 1'b1;
    endcase
  end

  // Transmit engine, stop state length from the setup field
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      st_q  <= line_setup_pkg::TX_IDLE;
      sub_q <= 6'h00;
      bit_q <= 3'h0;
      sh_q  <= 8'h00;
      par_q <= 1'b0;
    end else if (start) begin
      st_q  <= line_setup_pkg::TX_START;
      sub_q <= 6'h00;
      bit_q <= 3'h0;
      sh_q  <= next_char;
      par_q <= PAR_ODD_I;
    end else if (bit_end) begin
      sub_q <= 6'h00;
      unique case (st_q)
        line_setup_pkg::TX_START: st_q <= line_setup_pkg::TX_DATA;
        line_setup_pkg::TX_DATA: begin
          sh_q  <= sh_q >> 1;
          par_q <= par_q ^ sh_q[0];
          bit_q <= bit_q + 3'h1;
          if (bit_q == last_bit) begin
            st_q <= PAR_EN_I ? line_setup_pkg::TX_PARITY
                             : line_setup_pkg::TX_STOP;
          end
        end
        line_setup_pkg::TX_PARITY: st_q <= line_setup_pkg::TX_STOP;
        line_setup_pkg::TX_STOP:   st_q <= line_setup_pkg::TX_IDLE;
        line_setup_pkg::TX_IDLE:   st_q <= line_setup_pkg::TX_IDLE;
      endcase
    end else if (TX_TICK_I && st_q != line_setup_pkg::TX_IDLE) begin
      sub_q <= sub_q + 6'h01;
    end
  end

  // Flow characters and Xoff pause
  logic want_xoff, want_xon, host_ok;
  assign want_xoff = flow_mode[1] && !xoff_sent_q
                   && (RXQ_LEVEL_I >= `XOFF_LEVEL);
  assign want_xon  = flow_mode[1] && xoff_sent_q
                   && (RXQ_LEVEL_I <= `XON_LEVEL);
  assign host_ok   = (flow_mode == 2'h0);
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      send_q      <= 2'h0;
      hold_q      <= 1'b0;
      xoff_sent_q <= 1'b0;
    end else begin
      // A new request beats the clear of a started one
      send_q <= (start ? {1'b0, send_q[1] ? send_q[0] : 1'b0}
                       : send_q)
              | {want_xoff || (host_ok && SEND_XOFF_I),
                 want_xon || (host_ok && SEND_XON_I)};
      if (want_xoff) begin
        xoff_sent_q <= 1'b1;
      end else if (want_xon || !flow_mode[1]) begin
        xoff_sent_q <= 1'b0;
      end
      // Received flow characters gate new data characters
      if (!flow_mode[0]) begin
        hold_q <= 1'b0;
      end else if (RXC_VALID_I && RXC_FLOW_I) begin
        hold_q <= RXC_XOFF_I;
      end
    end
  end

  // Request-to-send: commands, plus negation after drain
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      RTS_N_O   <= 1'b1;
      armed_q   <= 1'b0;
      rts_cnt_q <= 6'h00;
    end else begin
      if (start) begin
        armed_q   <= mr2_q[`RTS_AUTO_BIT];
        rts_cnt_q <= 6'h00;
      end else if (!mr2_q[`RTS_AUTO_BIT]) begin
        armed_q <= 1'b0;
      end else if (armed_q && tx_done && TX_TICK_I) begin
        // One bit time after the last stop bit
        if (rts_cnt_q == blen - 6'h01) begin
          RTS_N_O <= 1'b1;
          armed_q <= 1'b0;
        end else begin
          rts_cnt_q <= rts_cnt_q + 6'h01;
        end
      end
      if (RTS_SET_I) begin
        RTS_N_O <= 1'b0;
      end else if (RTS_CLR_I) begin
        RTS_N_O <= 1'b1;
      end
    end
  end

  // Receiver 1X resample; a held break stays low until it ends
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      rx_ph_q <= 4'h0;
      echo_q  <= 1'b1;
    end else if (RX_TICK_I) begin
      rx_ph_q <= rx_ph_q + 4'h1;
      if (rx_ph_q == `SUB_MID) begin
        echo_q <= RXD_I;
      end
    end
  end

  // Pin and receiver-core muxing by mode
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      TXD_O     <= 1'b1;
      RX_LINE_O <= 1'b1;
      RX_TICK_O <= 1'b0;
    end else begin
      // Parity and stop bits go out exactly as received
      TXD_O <= is_local ? 1'b1
             : resend ? echo_q : tx_bit;
      // Core checks first stop centre only; line is fed as is
      RX_LINE_O <= is_local ? tx_bit : RXD_I;
      RX_TICK_O <= is_local ? TX_TICK_I : RX_TICK_I;
    end
  end

  // Receive delivery, stripping and error accumulation
  logic strip, deliver;
  logic [2:0] stat, acc_d;
  assign strip   = (RXC_FLOW_I && mr3_q[`STRIP_FLOW_BIT])
                 || (RXC_ADDR_I && mr3_q[`STRIP_ADDR_BIT]);
  assign deliver = RXC_VALID_I && !is_remote && !strip;
  assign stat    = is_remote ? 3'h0 : RXC_STAT_I;
  // Set wins over the reset command
  assign acc_d   = (ERR_RESET_I ? 3'h0 : ERR_ACC_O)
                 | ((RXC_VALID_I && BLOCK_ERR_I) ? stat : 3'h0);
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      RXQ_WR_O   <= 1'b0;
      RXQ_DATA_O <= 8'h00;
      RXQ_STAT_O <= 3'h0;
      ERR_ACC_O  <= 3'h0;
      RECOG_O    <= 1'b0;
    end else begin
      RXQ_WR_O   <= deliver;
      RXQ_DATA_O <= RXC_DATA_I;
      RXQ_STAT_O <= stat;
      // Stripped status survives only in the accumulator
      ERR_ACC_O  <= acc_d;
      // Recognition event unaffected by stripping
      RECOG_O    <= RXC_VALID_I && (RXC_FLOW_I || RXC_ADDR_I);
    end
  end

  // Status outputs; echo and remote loop clear TX_RDY_O and TX_IDLE_O, TXD_READY_O follows the queue
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      TX_RDY_O    <= 1'b0;
      TX_IDLE_O   <= 1'b0;
      TXD_READY_O <= 1'b0;
    end else begin
      TX_RDY_O    <= q_ready && TX_EN_I && !resend;
      TX_IDLE_O   <= tx_done && TX_EN_I && !resend;
      TXD_READY_O <= q_ready;
    end
  end

  // Register writes and legacy pointer stepping
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      mr2_q <= `LS_RESET;
      mr3_q <= `FA_RESET;
      ptr_q <= 2'h0;
    end else begin
      if (WR_I && ls_hit) begin
        mr2_q <= WDATA_I;
      end
      if (WR_I && fa_hit) begin
        mr3_q <= WDATA_I & `FA_RW_MASK;
      end
      // Saturates at the last stage
      if ((WR_I || RD_I) && ptr_hit && ptr_q != `PTR_LAST) begin
        ptr_q <= ptr_q + 2'h1;
      end
    end
  end

  // Read data, zero for unmapped offsets
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      RDATA_O <= 8'h00;
    end else if (RD_I) begin
      RDATA_O <= ls_hit ? mr2_q : fa_hit ? mr3_q : 8'h00;
    end
  end

  // Checks
  local_txd_a: assert property (
    @(posedge CLK_I) disable iff (!RSTN_I)
    is_local |=> TXD_O)
    else $error("local loop did not hold output high");
  remote_drop_a: assert property (
    @(posedge CLK_I) disable iff (!RSTN_I)
    (RXC_VALID_I && is_remote) |=> !RXQ_WR_O && RXQ_STAT_O == 3'h0)
    else $error("remote loop delivered a character");
  strip_flow_a: assert property (
    @(posedge CLK_I) disable iff (!RSTN_I)
    (RXC_VALID_I && RXC_FLOW_I && mr3_q[`STRIP_FLOW_BIT])
      |=> !RXQ_WR_O)
    else $error("stripped flow character was queued");
  cts_hold_a: assert property (
    @(posedge CLK_I) disable iff (!RSTN_I)
    (st_q == line_setup_pkg::TX_IDLE && mr2_q[`CTS_EN_BIT]
      && CTS_N_I) |=> st_q == line_setup_pkg::TX_IDLE)
    else $error("character started with clear-to-send high");
  echo_flags_a: assert property (
    @(posedge CLK_I) disable iff (!RSTN_I)
    is_echo |=> !TX_RDY_O && !TX_IDLE_O)
    else $error("ready flags active in echo mode");
  echo_path_a: assert property (
    @(posedge CLK_I) disable iff (!RSTN_I)
    is_echo |=> TXD_O == $past(echo_q))
    else $error("echo output not the re-clocked input");
  acc_sticky_a: assert property (
    @(posedge CLK_I) disable iff (!RSTN_I)
    !ERR_RESET_I |=> (ERR_ACC_O & $past(ERR_ACC_O))
                     == $past(ERR_ACC_O))
    else $error("accumulated error lost without reset");
  host_xoff_a: assert property (
    @(posedge CLK_I) disable iff (!RSTN_I)
    (flow_mode == 2'h1 && SEND_XOFF_I && !send_q[1])
      |=> !send_q[1])
    else $error("host Xoff taken with auto flow set");
endmodule // line_setup

//--- sim/line_partner.sv
// Purpose: remote serial station facing the channel's pins
// Assumes: BIT_CYC clocks per bit, 8 data bits, no parity
// Notes:   line rests at mark between frames, as a real line does
`timescale 1ns/1ns
module line_partner #(
  parameter int BIT_CYC = 64  // Clocks per bit time
) (
  // Clock
  input  wire logic clk_i,
  // Serial pins
  input  wire logic txd_i,    // Channel serial output
  output logic      rxd_o     // Channel serial input
);
  initial rxd_o = 1'b1;

  // One frame out: start, data LSB first, one stop
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i);
      #1;
      rxd_o = f[i];
      repeat (BIT_CYC - 1) @(posedge clk_i);
    end
  endtask

  // One frame in; ok low on timeout or missing stop mark
  task automatic recv(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    b = 8'h00;
    // Bounded hunt for the start edge
    while (txd_i !== 1'b0 && n < 20000) begin
      @(posedge clk_i);
      #2;
      n++;
    end
    if (n < 20000) begin
      // Centre sampling keeps clear of bit edges
      repeat (BIT_CYC / 2) @(posedge clk_i);
      for (int i = 0; i < 9; i++) begin
        repeat (BIT_CYC) @(posedge clk_i);
        if (i < 8) b[i] = txd_i;
      end
      ok = (txd_i === 1'b1);
    end
  endtask
endmodule // line_partner

//--- sim/line_setup_tb.sv
// Purpose: self-checking bench for one line setup channel
// Assumes: a tick every 4 clocks, so one bit is 64 clocks
// Notes:   8-bit characters without parity throughout
`timescale 1ns/1ns
module line_setup_tb;
  // Host side drive
  logic       clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, txd_data = 8'h00;
  logic       tx_en = 1'b1, rts_set = 1'b0, rts_clr = 1'b0;
  logic       s_xon = 1'b0, s_xoff = 1'b0, e_rst = 1'b0, blk = 1'b0;
  logic       txd_valid = 1'b0, cts_n = 1'b1, tick = 1'b0;
  // Receiver core stand-in
  logic [7:0] rxc_data = 8'h00;
  logic [2:0] rxc_stat = 3'h0;
  logic       rxc_valid = 1'b0, rxc_flow = 1'b0, rxc_addr = 1'b0;
  logic       rxc_xoff = 1'b0;
  logic [8:0] rxq_level = 9'h000;
  // Design outputs and bench state
  logic [7:0] rdata, rxq_data;
  logic [2:0] rxq_stat, err_acc;
  logic       txd_ready, tx_rdy, tx_idle, txd, rts_n, rx_line, rxq_wr;
  logic       rxd, saw_lo, rx_tick, recog;
  logic [1:0] tk_cnt = 2'h0;
  int         n_errors = 0, total_checks = 0, bad, n, n_tk;

  line_setup uut (
    .CLK_I(clk), .RSTN_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .TX_EN_I(tx_en),
    .RTS_SET_I(rts_set), .RTS_CLR_I(rts_clr), .SEND_XON_I(s_xon),
    .SEND_XOFF_I(s_xoff), .ERR_RESET_I(e_rst), .BLOCK_ERR_I(blk),
    .BITS_I(2'h3), .PAR_EN_I(1'b0), .PAR_ODD_I(1'b0),
    .TXD_DATA_I(txd_data), .TXD_VALID_I(txd_valid),
    .TXD_READY_O(txd_ready), .TX_RDY_O(tx_rdy), .TX_IDLE_O(tx_idle),
    .TX_TICK_I(tick), .RX_TICK_I(tick), .TX_EXT1X_I(1'b0),
    .RXD_I(rxd), .TXD_O(txd), .CTS_N_I(cts_n), .RTS_N_O(rts_n),
    .RX_LINE_O(rx_line), .RX_TICK_O(rx_tick), .RXC_DATA_I(rxc_data),
    .RXC_VALID_I(rxc_valid), .RXC_STAT_I(rxc_stat),
    .RXC_FLOW_I(rxc_flow), .RXC_XOFF_I(rxc_xoff), .RXC_ADDR_I(rxc_addr),
    .RXQ_LEVEL_I(rxq_level), .RXQ_WR_O(rxq_wr), .RXQ_DATA_O(rxq_data),
    .RXQ_STAT_O(rxq_stat), .ERR_ACC_O(err_acc), .RECOG_O(recog)
  );
  line_partner far (.clk_i(clk), .txd_i(txd), .rxd_o(rxd));

  // Clock and 16x baud tick
  always #50 clk = ~clk;
  always @(posedge clk) begin
    tk_cnt <= tk_cnt + 2'h1;
    tick   <= (tk_cnt == 2'h3);
  end

  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [11:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // Strobes get an idle cycle after, so no double drive per step
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(1);
  endtask
  task automatic wreg(input logic [7:0] a, d);
    addr = a;
    wdata = d;
    pulse(wr);
  endtask
  task automatic rreg(input logic [7:0] a, e);
    addr = a;
    rd = 1'b1;
    cyc(1);
    chk("rdata", rdata, e);
    rd = 1'b0;
    cyc(1);
  endtask
  task automatic push(input logic [7:0] d);
    n = 0;
    while (txd_ready !== 1'b1 && n < 5000) begin
      cyc(1);
      n++;
    end
    chk("ready_wait", n < 5000, 1);
    if (n >= 5000) end_sim;
    txd_data = d;
    pulse(txd_valid);
  endtask
  task automatic get(input logic [7:0] e);
    logic [7:0] b;
    logic       ok;
    far.recv(b, ok);
    chk("frame", ok, 1);
    if (!ok) end_sim;
    chk("line_byte", b, e);
  endtask
  // Watches the output pin at mark; notes loop line activity
  task automatic quiet(input int k);
    bad = 0;
    n_tk = 0;
    repeat (k) begin
      cyc(1);
      if (txd !== 1'b1) bad++;
      if (rx_line === 1'b0) saw_lo = 1'b1;
      if (rx_tick === 1'b1) n_tk++;
    end
  endtask
  task automatic rxc(input logic [7:0] d, input logic f, a,
                     input logic [2:0] s, input logic e);
    rxc_data = d;
    rxc_flow = f;
    rxc_addr = a;
    rxc_stat = s;
    rxc_valid = 1'b1;
    cyc(1);
    chk("rxq_wr", rxq_wr, e);
    chk("recog", recog, f | a);
    if (e) chk("rxq_entry", {rxq_stat, rxq_data}, {s, d});
    rxc_valid = 1'b0;
    cyc(1);
  endtask

  // Main sequence
  initial begin
    cyc(6);
    rst_n = 1'b1;
    chk("rts_rst", rts_n, 1);
    rreg(8'h22, 8'h00);
    wreg(8'h22, 8'h07);
    wreg(8'h23, 8'hff);
    rreg(8'h22, 8'h07);
    rreg(8'h23, 8'hcf);
    rreg(8'h30, 8'h00);
    rreg(8'h00, 8'h00);
    rreg(8'h00, 8'h00);
    rreg(8'h00, 8'h07);
    rreg(8'h00, 8'hcf);
    for (int i = 3; i >= 0; i--) begin
      wreg(8'h23, {4'h0, i[1:0], 2'h0});
      rreg(8'h23, {4'h0, i[1:0], 2'h0});
    end
    // Clear-to-send high but not enabled
    push(8'ha5);
    get(8'ha5);
    // Queue fills while clear-to-send holds it back
    wreg(8'h22, 8'h17);
    for (int i = 0; i < 4; i++) push(8'h30 + i[7:0]);
    cyc(2);
    chk("txd_ready", txd_ready, 0);
    quiet(200);
    chk("mark_held", bad, 0);
    cts_n = 1'b0;
    fork
      get(8'h30);
      begin
        cyc(300);
        cts_n = 1'b1;
        cyc(200);
        cts_n = 1'b0;
      end
    join
    for (int i = 1; i < 4; i++) get(8'h30 + i[7:0]);
    chk("txd_ready", txd_ready, 1);
    // Request-to-send commands and automatic negation
    wreg(8'h22, 8'h27);
    pulse(rts_set);
    chk("rts_n", rts_n, 0);
    pulse(rts_clr);
    chk("rts_n", rts_n, 1);
    pulse(rts_set);
    push(8'h3c);
    get(8'h3c);
    chk("rts_n", rts_n, 0);
    n = 0;
    while (rts_n !== 1'b1 && n < 300) begin
      cyc(1);
      n++;
    end
    chk("rts_delay", n >= 64 && n <= 128, 1);
    if (n >= 300) end_sim;
    // Host flow characters, then barred by a nonzero field
    wreg(8'h22, 8'h07);
    pulse(s_xon);
    get(8'h11);
    wreg(8'h23, 8'h04);
    pulse(s_xoff);
    quiet(700);
    chk("no_xoff", bad, 0);
    // Received Xoff holds host data under auto transmit flow
    rxc_xoff = 1'b1;
    rxc(8'h13, 1'b1, 1'b0, 3'h0, 1'b1);
    push(8'h77);
    quiet(300);
    chk("xoff_hold", bad, 0);
    rxc_xoff = 1'b0;
    rxc(8'h11, 1'b1, 1'b0, 3'h0, 1'b1);
    get(8'h77);
    // Receive queue level alone sends Xoff, then Xon
    wreg(8'h23, 8'h08);
    rxq_level = 9'h0f0;
    get(8'h13);
    rxq_level = 9'h080;
    get(8'h11);
    wreg(8'h23, 8'h00);
    // Local loop
    wreg(8'h22, 8'h87);
    saw_lo = 1'b0;
    push(8'h5a);
    quiet(900);
    chk("txd_high", bad, 0);
    chk("loop_line", saw_lo, 1);
    chk("rx_tick", n_tk, 225);
    // Echo
    wreg(8'h22, 8'h47);
    fork
      far.send(8'hc3);
      get(8'hc3);
    join
    chk("tx_rdy", tx_rdy, 0);
    chk("tx_idle", tx_idle, 0);
    push(8'h00);
    quiet(300);
    chk("no_host_tx", bad, 0);
    rxc(8'h55, 1'b0, 1'b0, 3'h1, 1'b1);
    // Remote loop
    wreg(8'h22, 8'hc7);
    fork
      far.send(8'h96);
      get(8'h96);
    join
    rxc(8'h66, 1'b0, 1'b0, 3'h2, 1'b0);
    // Stripping and block error accumulation
    wreg(8'h22, 8'h07);
    wreg(8'h23, 8'hc0);
    blk = 1'b1;
    pulse(e_rst);
    rxc(8'h13, 1'b1, 1'b0, 3'h2, 1'b0);
    rxc(8'h80, 1'b0, 1'b1, 3'h0, 1'b0);
    chk("err_acc", err_acc, 3'h2);
    rxc(8'h41, 1'b0, 1'b0, 3'h4, 1'b1);
    chk("err_acc", err_acc, 3'h6);
    pulse(e_rst);
    chk("err_acc", err_acc, 3'h0);
    wreg(8'h23, 8'h00);
    rxc(8'h13, 1'b1, 1'b0, 3'h1, 1'b1);
    end_sim;
  end
endmodule // line_setup_tb
